// *** rtl/port_ctl_pkg.sv ***
package port_ctl_pkg;
    // Bit positions, bit 31 is the most significant bit of the word
    localparam int POS_CAP = 31;
    localparam int POS_ACT = 29;
    localparam int POS_OVR = 26;
    localparam int POS_DIS = 23;
    localparam int POS_TXEN = 22;
    localparam int POS_RXEN = 21;
    localparam int POS_CRCDIS = 20;
    localparam int POS_MCE = 19;
    localparam int POS_ENUM = 17;
    localparam int POS_STOP = 3;
    localparam int POS_DROP = 2;
    localparam int POS_LOCK = 1;
    localparam int POS_TYPE = 0;
    localparam logic [2:0] OVR_KEEP = 3'h0;
    localparam logic [2:0] OVR_LANE0 = 3'h2;
    localparam logic [2:0] OVR_LANE2 = 3'h3;
    localparam logic [2:0] ACT_LANE0 = 3'h0;
    localparam logic [2:0] ACT_LANE2 = 3'h1;
    localparam logic [2:0] ACT_FOUR = 3'h2;
    localparam logic [1:0] CAP_FOUR = 2'h1;
    localparam logic [1:0] CAP_ONE = 2'h0;
    localparam logic [2:0] RST_OVR = 3'h0;
    localparam logic RST_DIS = 1'b0;
    localparam logic RST_TXEN = 1'b1;
    localparam logic RST_RXEN = 1'b1;
    localparam logic RST_MCE = 1'b0;
    localparam int ENUM_PORT = 2;
    localparam int REINIT_CYCLES = 1;

    typedef struct packed {
        logic [2:0] width_override;
        logic port_disable_bit;
        logic tx_enable;
        logic rx_enable;
        logic crc_check_disable;
        logic multicast_event_forward;
        logic enum_boundary;
        logic stop_on_fail;
        logic drop_on_fail;
    } ctl_fields_t;

    typedef struct packed {
        logic wr;
        logic [31:0] wdata;
        logic maint;
        logic crc_bad;
    } reg_wr_t;

    typedef struct packed {
        logic rx_drive_en;
        logic tx_drive_en;
        logic tx_zero;
        logic hold_queue;
        logic tx_maint_only;
        logic rx_maint_only;
        logic crc_check_en;
        logic retransmit_en;
        logic mcast_fwd;
        logic stop_send;
        logic drop_nack;
        logic odd_disable;
    } port_ctl_t;
endpackage

// *** rtl/serial_port_control_fields.sv ***
`timescale 1ns/1ns
`default_nettype none
module serial_port_control_fields #(
    parameter int PORT_NUM = 0
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register access
    input wire port_ctl_pkg::reg_wr_t reg_wr_in,
    input wire logic loader_wr_in,
    input wire logic [2:0] loader_override_in,
    output logic [31:0] serial_port_control_out,
    // Pins and link status
    input wire logic width_select_pin_in,
    input wire logic init_done_in,
    input wire logic [2:0] link_width_in,
    input wire logic reinit_request_in,
    input wire logic rate_fail_in,
    // Port control
    output var port_ctl_pkg::port_ctl_t port_ctl_out,
    output logic link_reinit_out,
    output logic [2:0] lane_mode_out
);
    typedef struct packed {
        port_ctl_pkg::ctl_fields_t f;
        logic [1:0] cap;
        logic [2:0] act;
        logic reinit;
        logic was_rst;
        logic [31:0] rd;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic [31:0] w;
    logic ovr_ok;
    logic reg_take;

    function automatic logic [2:0] lane_of(input logic [2:0] ov, input logic [2:0] act);
        // Reserved codes keep the current mode
        case (ov)
            port_ctl_pkg::OVR_LANE0: lane_of = port_ctl_pkg::ACT_LANE0;
            port_ctl_pkg::OVR_LANE2: lane_of = port_ctl_pkg::ACT_LANE2;
            default: lane_of = act;
        endcase
    endfunction

    assign w = reg_wr_in.wdata;
    assign reg_take = reg_wr_in.wr && !loader_wr_in && !(reg_wr_in.maint && reg_wr_in.crc_bad);
    // ************************
    // Next state
    // ************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.reinit = 1'b0;
        nxt_st.was_rst = 1'b0;
        if (st_ff.was_rst) begin
            nxt_st.cap = width_select_pin_in ? port_ctl_pkg::CAP_ONE :
                ((PORT_NUM % 2 == 0) ? port_ctl_pkg::CAP_FOUR : port_ctl_pkg::CAP_ONE);
        end
        if (init_done_in) begin
            nxt_st.act = link_width_in;
        end
        if (loader_wr_in) begin
            nxt_st.f.width_override = loader_override_in;
            nxt_st.reinit = loader_override_in != st_ff.f.width_override;
        end else if (reg_wr_in.wr && !(reg_wr_in.maint && reg_wr_in.crc_bad)) begin
            nxt_st.f.width_override = w[port_ctl_pkg::POS_OVR -: 3];
            nxt_st.reinit = w[port_ctl_pkg::POS_OVR -: 3] != st_ff.f.width_override;
            nxt_st.f.port_disable_bit = w[port_ctl_pkg::POS_DIS];
            nxt_st.f.tx_enable = w[port_ctl_pkg::POS_TXEN];
            nxt_st.f.rx_enable = w[port_ctl_pkg::POS_RXEN];
            nxt_st.f.crc_check_disable = w[port_ctl_pkg::POS_CRCDIS];
            nxt_st.f.multicast_event_forward = w[port_ctl_pkg::POS_MCE];
            nxt_st.f.enum_boundary = w[port_ctl_pkg::POS_ENUM];
            nxt_st.f.stop_on_fail = w[port_ctl_pkg::POS_STOP];
            nxt_st.f.drop_on_fail = w[port_ctl_pkg::POS_DROP];
        end
        if (reinit_request_in) begin
            nxt_st.reinit = 1'b1;
        end
        // Read image; unlisted bits stay zero
        nxt_st.rd = 32'h0000_0000;
        nxt_st.rd[port_ctl_pkg::POS_CAP -: 2] = nxt_st.cap;
        nxt_st.rd[port_ctl_pkg::POS_ACT -: 3] = nxt_st.act;
        nxt_st.rd[port_ctl_pkg::POS_OVR -: 3] = nxt_st.f.width_override;
        nxt_st.rd[port_ctl_pkg::POS_DIS] = nxt_st.f.port_disable_bit;
        nxt_st.rd[port_ctl_pkg::POS_TXEN] = nxt_st.f.tx_enable;
        nxt_st.rd[port_ctl_pkg::POS_RXEN] = nxt_st.f.rx_enable;
        nxt_st.rd[port_ctl_pkg::POS_CRCDIS] = nxt_st.f.crc_check_disable;
        nxt_st.rd[port_ctl_pkg::POS_MCE] = nxt_st.f.multicast_event_forward;
        nxt_st.rd[port_ctl_pkg::POS_ENUM] = nxt_st.f.enum_boundary;
        nxt_st.rd[port_ctl_pkg::POS_STOP] = nxt_st.f.stop_on_fail;
        nxt_st.rd[port_ctl_pkg::POS_DROP] = nxt_st.f.drop_on_fail;
        nxt_st.rd[port_ctl_pkg::POS_TYPE] = 1'b1;
    end

    // ************************
    // State register
    // ************************
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_ff <= '0;
            st_ff.f.width_override <= port_ctl_pkg::RST_OVR;
            st_ff.f.tx_enable <= port_ctl_pkg::RST_TXEN;
            st_ff.f.rx_enable <= port_ctl_pkg::RST_RXEN;
            st_ff.f.port_disable_bit <= port_ctl_pkg::RST_DIS;
            st_ff.f.multicast_event_forward <= port_ctl_pkg::RST_MCE;
            st_ff.f.enum_boundary <= (PORT_NUM == port_ctl_pkg::ENUM_PORT);
            st_ff.was_rst <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************
    // Port controls
    // ************************
    assign ovr_ok = (st_ff.cap == port_ctl_pkg::CAP_FOUR) && (st_ff.act == port_ctl_pkg::ACT_FOUR);
    always_comb begin
        lane_mode_out = ovr_ok ? lane_of(st_ff.f.width_override, st_ff.act) : st_ff.act;
        port_ctl_out.rx_drive_en = !st_ff.f.port_disable_bit;
        port_ctl_out.tx_drive_en = !st_ff.f.port_disable_bit;
        port_ctl_out.tx_zero = st_ff.f.port_disable_bit;
        port_ctl_out.hold_queue = st_ff.f.port_disable_bit;
        port_ctl_out.tx_maint_only = !st_ff.f.tx_enable;
        port_ctl_out.rx_maint_only = !st_ff.f.rx_enable;
        port_ctl_out.crc_check_en = !st_ff.f.crc_check_disable;
        port_ctl_out.retransmit_en = !st_ff.f.crc_check_disable;
        port_ctl_out.mcast_fwd = st_ff.f.multicast_event_forward && !st_ff.f.port_disable_bit;
        port_ctl_out.stop_send = st_ff.f.stop_on_fail && st_ff.f.drop_on_fail && rate_fail_in;
        port_ctl_out.drop_nack = st_ff.f.stop_on_fail && st_ff.f.drop_on_fail && rate_fail_in;
        // Even port with CAP_ONE capability in four-lane mode takes the odd port's lanes
        port_ctl_out.odd_disable = (PORT_NUM % 2 == 0) && (st_ff.cap == port_ctl_pkg::CAP_ONE)
            && (lane_mode_out == port_ctl_pkg::ACT_FOUR);
    end
    assign link_reinit_out = st_ff.reinit;
    assign serial_port_control_out = st_ff.rd;

    // ************************
    // Checks
    // ************************
    reinit_on_change_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in.wr && !loader_wr_in && !(reg_wr_in.maint && reg_wr_in.crc_bad)
         && w[port_ctl_pkg::POS_OVR -: 3] != st_ff.f.width_override) |=> link_reinit_out)
        else $error("override change without reinit");
    crc_bad_ignored_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in.wr && reg_wr_in.maint && reg_wr_in.crc_bad && !loader_wr_in)
        |=> $stable(st_ff.f.port_disable_bit) && $stable(st_ff.f.tx_enable))
        else $error("corrupt write changed register");
    reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        serial_port_control_out[16:4] == 13'h0000 && !serial_port_control_out[18])
        else $error("reserved bits nonzero");
    disable_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        serial_port_control_out[port_ctl_pkg::POS_DIS] |-> port_ctl_out.tx_zero
        && !port_ctl_out.tx_drive_en && port_ctl_out.hold_queue)
        else $error("disabled port still drives");
    stop_drop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.stop_send |-> rate_fail_in && serial_port_control_out[port_ctl_pkg::POS_DROP])
        else $error("stop without cause");
    override_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.cap != port_ctl_pkg::CAP_FOUR) |-> lane_mode_out == st_ff.act)
        else $error("override applied without capability");
    width_latch_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_ff.was_rst |=> $stable(st_ff.cap))
        else $error("capability followed pin after reset");
    active_width_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        init_done_in |=> st_ff.act == $past(link_width_in))
        else $error("active width not updated");

    // ************************
    // Write checks
    // ************************
    dis_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.port_disable_bit == $past(w[port_ctl_pkg::POS_DIS]))
        else $error("port disable write lost");

    tx_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.tx_enable == $past(w[port_ctl_pkg::POS_TXEN]))
        else $error("transmit enable write lost");

    rx_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.rx_enable == $past(w[port_ctl_pkg::POS_RXEN]))
        else $error("receive enable write lost");

    crc_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.crc_check_disable == $past(w[port_ctl_pkg::POS_CRCDIS]))
        else $error("crc disable write lost");

    mcast_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.multicast_event_forward == $past(w[port_ctl_pkg::POS_MCE]))
        else $error("multicast forward write lost");

    enum_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.enum_boundary == $past(w[port_ctl_pkg::POS_ENUM]))
        else $error("enumeration flag write lost");

    stop_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.stop_on_fail == $past(w[port_ctl_pkg::POS_STOP]))
        else $error("stop on fail write lost");

    drop_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.drop_on_fail == $past(w[port_ctl_pkg::POS_DROP]))
        else $error("drop on fail write lost");

    ovr_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_take |=> st_ff.f.width_override == $past(w[port_ctl_pkg::POS_OVR -: 3]))
        else $error("override write lost");

    loader_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        loader_wr_in |=> st_ff.f.width_override == $past(loader_override_in))
        else $error("loader value lost");

    loader_reinit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (loader_wr_in && loader_override_in != st_ff.f.width_override) |=> link_reinit_out)
        else $error("loader change without reinit");

    request_reinit_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reinit_request_in |=> link_reinit_out)
        else $error("reinit request ignored");

    reinit_cause_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        link_reinit_out |-> $past(reinit_request_in) || $past(loader_wr_in) || $past(reg_take))
        else $error("reinit without cause");

    corrupt_ovr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in.wr && reg_wr_in.maint && reg_wr_in.crc_bad && !loader_wr_in)
        |=> $stable(st_ff.f.width_override))
        else $error("corrupt write changed override");

    corrupt_enum_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (reg_wr_in.wr && reg_wr_in.maint && reg_wr_in.crc_bad)
        |=> $stable(st_ff.f.enum_boundary) && $stable(st_ff.f.crc_check_disable))
        else $error("corrupt write changed flags");

    act_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !init_done_in |=> $stable(st_ff.act))
        else $error("active width moved without init");

    cap_high_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.was_rst && width_select_pin_in) |=> st_ff.cap == port_ctl_pkg::CAP_ONE)
        else $error("pin high capability wrong");

    cap_low_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.was_rst && !width_select_pin_in) |=> st_ff.cap ==
        ((PORT_NUM % 2 == 0) ? port_ctl_pkg::CAP_FOUR : port_ctl_pkg::CAP_ONE))
        else $error("pin low capability wrong");

    cap_image_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        serial_port_control_out[port_ctl_pkg::POS_CAP -: 2] == st_ff.cap)
        else $error("capability image wrong");

    // ************************
    // Control checks
    // ************************
    lane0_force_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.cap == port_ctl_pkg::CAP_FOUR && st_ff.act == port_ctl_pkg::ACT_FOUR
         && st_ff.f.width_override == port_ctl_pkg::OVR_LANE0)
        |-> lane_mode_out == port_ctl_pkg::ACT_LANE0)
        else $error("lane 0 override not applied");

    lane2_force_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.cap == port_ctl_pkg::CAP_FOUR && st_ff.act == port_ctl_pkg::ACT_FOUR
         && st_ff.f.width_override == port_ctl_pkg::OVR_LANE2)
        |-> lane_mode_out == port_ctl_pkg::ACT_LANE2)
        else $error("lane 2 override not applied");

    keep_mode_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.f.width_override != port_ctl_pkg::OVR_LANE0
         && st_ff.f.width_override != port_ctl_pkg::OVR_LANE2) |-> lane_mode_out == st_ff.act)
        else $error("keep code changed mode");

    four_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.act != port_ctl_pkg::ACT_FOUR) |-> lane_mode_out == st_ff.act)
        else $error("override applied outside four lanes");

    odd_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ((PORT_NUM % 2 == 0) && st_ff.cap == port_ctl_pkg::CAP_ONE
         && lane_mode_out == port_ctl_pkg::ACT_FOUR) |-> port_ctl_out.odd_disable)
        else $error("odd port left enabled");

    odd_cause_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.odd_disable |-> lane_mode_out == port_ctl_pkg::ACT_FOUR)
        else $error("odd port disabled without cause");

    rx_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        st_ff.f.port_disable_bit |-> !port_ctl_out.rx_drive_en && !port_ctl_out.mcast_fwd)
        else $error("disabled port still receives");

    enabled_drive_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_ff.f.port_disable_bit |-> port_ctl_out.tx_drive_en && !port_ctl_out.tx_zero
        && !port_ctl_out.hold_queue)
        else $error("enabled port not driving");

    tx_maint_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.tx_maint_only != st_ff.f.tx_enable)
        else $error("transmit maintenance mode wrong");

    rx_maint_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.rx_maint_only != st_ff.f.rx_enable)
        else $error("receive maintenance mode wrong");

    crc_ctl_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.crc_check_en != st_ff.f.crc_check_disable
        && port_ctl_out.retransmit_en != st_ff.f.crc_check_disable)
        else $error("crc checking control wrong");

    mcast_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.mcast_fwd == (st_ff.f.multicast_event_forward && !st_ff.f.port_disable_bit))
        else $error("multicast forwarding wrong");

    fail_act_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st_ff.f.stop_on_fail && st_ff.f.drop_on_fail && rate_fail_in)
        |-> port_ctl_out.stop_send && port_ctl_out.drop_nack)
        else $error("failed port keeps sending");

    drop_cause_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_ctl_out.drop_nack |-> rate_fail_in && st_ff.f.stop_on_fail && st_ff.f.drop_on_fail)
        else $error("drop without cause");
endmodule
`default_nettype wire

// *** verification/link_partner_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module link_partner_model #(
    parameter int TRAIN_CYCLES = 6
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // From the port
    input wire logic link_reinit_in,
    input wire logic [2:0] width_in,
    // Link status
    output logic init_done_out,
    output logic [2:0] link_width_out
);
    int cnt_ff;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || link_reinit_in) begin
            cnt_ff <= TRAIN_CYCLES;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // One done pulse per training
    assign init_done_out = (cnt_ff == 1);
    // Width is only valid with done, so show garbage otherwise
    assign link_width_out = init_done_out ? width_in : ~width_in;
endmodule
`default_nettype wire

// *** verification/test_serial_port_control_fields.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_control_fields;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    port_ctl_pkg::reg_wr_t wr = '0;
    logic ld_wr = 1'b0;
    logic [2:0] ld_val = 3'h0;
    logic pin = 1'b0;
    logic rq = 1'b0;
    logic fail = 1'b0;
    logic [2:0] pw = 3'h2;
    logic done;
    logic [2:0] lw;
    logic [31:0] img;
    port_ctl_pkg::port_ctl_t pc;
    logic reinit;
    logic [2:0] lane;
    int num_errors = 0;
    int n_compared = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    serial_port_control_fields i_serial_port_control_fields (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .reg_wr_in(wr), .loader_wr_in(ld_wr), .loader_override_in(ld_val),
        .serial_port_control_out(img), .width_select_pin_in(pin), .init_done_in(done),
        .link_width_in(lw), .reinit_request_in(rq), .rate_fail_in(fail),
        .port_ctl_out(pc), .link_reinit_out(reinit), .lane_mode_out(lane));
    link_partner_model i_link_partner_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link_reinit_in(reinit), .width_in(pw), .init_done_out(done), .link_width_out(lw));
    // ****************
    // Helpers
    // ****************
    task automatic summarize;
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] d, input logic m, input logic bad);
        @(posedge clk_sys_in);
        wr <= '{wr: 1'b1, wdata: d, maint: m, crc_bad: bad};
        @(posedge clk_sys_in);
        wr.wr <= 1'b0;
        #1;
    endtask
    task automatic wait_done;
        int i = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            i++;
        end while (i < 20 && done !== 1'b1);
        if (done !== 1'b1) begin
            num_errors++;
            summarize;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_width;
        for (int w = 0; w < 3; w++) begin
            @(posedge clk_sys_in);
            pw <= w[2:0];
            rq <= 1'b1;
            @(posedge clk_sys_in);
            rq <= 1'b0;
            #1;
            chk({31'h0, reinit}, 32'h1);
            wait_done;
            @(posedge clk_sys_in);
            #1;
            chk({29'h0, img[29:27]}, 32'(w));
        end
        @(posedge clk_sys_in);
        pin <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk({30'h0, img[31:30]}, 32'h1);
    endtask
    task automatic t_override;
        wr_reg(32'h0260_0000, 1'b0, 1'b0);
        chk({31'h0, reinit}, 32'h1);
        chk({29'h0, lane}, {29'h0, port_ctl_pkg::ACT_LANE0});
        wr_reg(32'h0260_0000, 1'b0, 1'b0);
        chk({31'h0, reinit}, 32'h0);
        wr_reg(32'h0360_0000, 1'b0, 1'b0);
        chk({29'h0, lane}, {29'h0, port_ctl_pkg::ACT_LANE2});
        wr_reg(32'h0060_0000, 1'b0, 1'b0);
        chk({29'h0, lane}, {29'h0, port_ctl_pkg::ACT_FOUR});
        @(posedge clk_sys_in);
        ld_val <= 3'h3;
        ld_wr <= 1'b1;
        @(posedge clk_sys_in);
        ld_wr <= 1'b0;
        #1;
        chk({29'h0, img[26:24]}, 32'h3);
        chk({31'h0, reinit}, 32'h1);
    endtask
    task automatic t_fields;
        wr_reg(32'hF8FF_FFFF, 1'b0, 1'b0);
        chk(img, 32'h50FA_000D);
        chk({20'h0, pc}, 32'h300);
        wr_reg(32'h0080_0000, 1'b1, 1'b1);
        chk(img, 32'h50FA_000D);
        wr_reg(32'h0000_0000, 1'b0, 1'b0);
        chk({20'h0, pc}, 32'hCF0);
        wr_reg(32'h0060_000C, 1'b0, 1'b0);
        chk({20'h0, pc}, 32'hC30);
        @(posedge clk_sys_in);
        fail <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk({20'h0, pc}, 32'hC36);
    endtask
    task automatic t_reset_pin;
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        #1;
        chk(img, 32'h1060_0001);
        chk({20'h0, pc}, 32'hC31);
        wr_reg(32'h0268_0000, 1'b0, 1'b0);
        chk({29'h0, lane}, {29'h0, port_ctl_pkg::ACT_FOUR});
        chk({20'h0, pc}, 32'hC39);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(img, 32'h4060_0001);
        chk({20'h0, pc}, 32'hC30);
        t_width;
        t_override;
        t_fields;
        t_reset_pin;
        summarize;
    end
endmodule
`default_nettype wire
